// ### include/nfh_pkg.sv
// Constants and types shared by the NAND flash host controller.
// Assumes a single 200 MHz clock; all times are converted to cycles here.
package nfh_pkg;

	// ------------------------------------------------------------
	// Clock and pin timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T_SETUP_NS    = 10; // Latch strobes settle before edge
	localparam int T_LOW_NS      = 25; // Write or read strobe low time
	localparam int T_HOLD_NS     = 20; // Strobe high time, values held
	localparam int T_BUSY_NS     = 100; // Wait before sampling ready/busy
	// Least times round up to whole cycles
	localparam int T_SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_LOW_CYC   = (T_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_HOLD_CYC  = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_BUSY_CYC  = (T_BUSY_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int TMR_W       = 8;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ      = 8'h00;
	localparam logic [7:0] CMD_READ_GO   = 8'h30;
	localparam logic [7:0] CMD_READ_CB   = 8'h35;
	localparam logic [7:0] CMD_CACHE_RD  = 8'h31;
	localparam logic [7:0] CMD_CACHE_END = 8'h34;
	localparam logic [7:0] CMD_PROG      = 8'h80;
	localparam logic [7:0] CMD_PROG_GO   = 8'h10;
	localparam logic [7:0] CMD_CACHE_PG  = 8'h15;
	localparam logic [7:0] CMD_CB_PROG   = 8'h85;
	localparam logic [7:0] CMD_ERASE     = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO  = 8'hd0;
	localparam logic [7:0] CMD_READ_ID   = 8'h90;
	localparam logic [7:0] CMD_RESET     = 8'hff;
	localparam logic [7:0] CMD_STATUS    = 8'h70;
	localparam logic [7:0] CMD_EXT_STAT  = 8'h72;
	localparam logic [7:0] CMD_RAND_OUT  = 8'h05;
	localparam logic [7:0] CMD_RAND_GO   = 8'he0;

	// ------------------------------------------------------------
	// Address cycles: index of first byte and count per operation
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_ZERO_IDX = 3'h5; // Selects a 00h byte
	localparam logic [2:0] ADDR_ROW_IDX  = 3'h2; // First block/row byte
	localparam logic [2:0] ADDR_FULL_CNT = 3'h5;
	localparam logic [2:0] ADDR_ROW_CNT  = 3'h3;
	localparam logic [2:0] ADDR_COL_CNT  = 3'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_READ       = 4'h0,
		OP_READ_CB    = 4'h1,
		OP_CACHE_RD   = 4'h2,
		OP_CACHE_END  = 4'h3,
		OP_PROG       = 4'h4,
		OP_CACHE_PROG = 4'h5,
		OP_CB_PROG    = 4'h6,
		OP_ERASE      = 4'h7,
		OP_READ_ID    = 4'h8,
		OP_RESET      = 4'h9,
		OP_STATUS     = 4'ha,
		OP_EXT_STAT   = 4'hb,
		OP_RAND_OUT   = 4'hc,
		OP_RAND_IN    = 4'hd
	} nfh_op_t;

	typedef struct packed {
		logic [7:0] cmd1;
		logic [7:0] cmd2;
		logic       hasCmd2;
		logic [2:0] addrFirst;
		logic [2:0] addrCnt;
		logic       dataIn;
		logic       waitBusy;
		logic       dataOut;
		logic       modify;
	} nfh_desc_t;

endpackage

// ### include/nfh_stream_if.sv
// Valid/ready word stream between the controller's own modules.
// Assumes source and sink share one clock.
`timescale 1ns/1ps
interface nfh_stream_if #(parameter int WIDTH = 16);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### hw/nfh_fifo.sv
// Synchronous FIFO with registered ready on the filling side.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module nfh_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic  mclk,
	input  wire logic  rst_n,
	nfh_stream_if.snk  inPort,
	nfh_stream_if.src  outPort
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r, wrPtr_nxt;
	logic [AW-1:0]    rdPtr_r, rdPtr_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             inReady_r, inReady_nxt;
	logic             push;
	logic             pop;

	// ------------------------------------------------------------
	// Pointers and fill count
	// ------------------------------------------------------------
	// Ready is registered so the top sees a flop; it looks ahead one word
	always_comb begin
		push        = inPort.valid && inReady_r;
		pop         = outPort.ready && (cnt_r != '0);
		wrPtr_nxt   = push ? AW'((wrPtr_r + 1'b1) % DEPTH) : wrPtr_r;
		rdPtr_nxt   = pop ? AW'((rdPtr_r + 1'b1) % DEPTH) : rdPtr_r;
		cnt_nxt     = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		inReady_nxt = (cnt_nxt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrPtr_r   <= '0;
			rdPtr_r   <= '0;
			cnt_r     <= '0;
			inReady_r <= 1'b0;
		end else begin
			wrPtr_r   <= wrPtr_nxt;
			rdPtr_r   <= rdPtr_nxt;
			cnt_r     <= cnt_nxt;
			inReady_r <= inReady_nxt;
		end
	end

	// Storage needs no reset; empty flag guards stale words
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_r] <= inPort.data;
		end
	end

	assign inPort.ready  = inReady_r;
	assign outPort.valid = (cnt_r != '0);
	assign outPort.data  = mem[rdPtr_r];
endmodule // nfh_fifo

// ### hw/nfh_addr_map.sv
// Splits a linear flash address into the five address-cycle bytes.
// Assumes the organisation is fixed at build time by BUS16.
`timescale 1ns/1ps
module nfh_addr_map #(
	parameter bit BUS16 = 1'b0
) (
	input  wire logic [29:0] addr,
	output logic      [7:0]  cycleByte [6]
);
	// ------------------------------------------------------------
	// Byte layout per organisation
	// ------------------------------------------------------------
	// Unused high lines of each byte are forced low
	always_comb begin
		cycleByte[0] = addr[7:0];
		if (BUS16) begin
			cycleByte[1] = {5'h00, addr[10:8]};
			cycleByte[2] = addr[18:11];
			cycleByte[3] = addr[26:19];
			cycleByte[4] = {6'h00, addr[28:27]};
		end else begin
			cycleByte[1] = {4'h0, addr[11:8]};
			cycleByte[2] = addr[19:12];
			cycleByte[3] = addr[27:20];
			cycleByte[4] = {6'h00, addr[29:28]};
		end
		cycleByte[5] = 8'h00; // Read ID address byte
	end
endmodule // nfh_addr_map

// ### hw/nfh_host.sv
// Host-side controller that drives a NAND flash through its pins.
// Assumes synchronous pin inputs, one 200 MHz clock, external I/O pads.
//
// What this block does
// - Command: CE low, CLE high, ALE low.
// - Commands and addresses use I/O 7..0.
// - Address: CE low, ALE high, CLE low.
// - Full address is five cycles, 30 bits for x8, 29 bits for x16.
// - x8 address byte layout, unused lines low.
// - x16 address byte layout, unused lines low.
// - Reads: 00h then 30h, 35h, 31h; 34h exits.
// - Program: 80h/10h, 80h/15h, 85h/10h.
// - Data in: both latches low, protect high.
// - Data out per read strobe, latches low.
// - Erase: 60h, three block cycles, confirm.
`timescale 1ns/1ps
module nfh_host #(
	parameter bit BUS16 = 1'b0,
	parameter int LEN_W = 12,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire logic                  reqValid,
	input  wire nfh_pkg::nfh_op_t      reqOp,
	input  wire logic [29:0]           reqAddr,
	input  wire logic [LEN_W-1:0]      reqLen,
	output logic                       reqReady,
	output logic                       done,
	input  wire logic                  wrValid,
	input  wire logic [15:0]           wrData,
	output logic                       wrReady,
	output logic                       rdValid,
	output logic [15:0]                rdData,
	output logic                       ceN,
	output logic                       cmdLatch,
	output logic                       addrLatch,
	output logic                       weN,
	output logic                       readStrobeN,
	output logic                       wpN,
	output logic [15:0]                ioOut,
	output logic                       ioOeN,
	input  wire logic [15:0]           ioIn,
	input  wire logic                  readyBusyN
);
	localparam int TW = nfh_pkg::TMR_W;
	localparam logic [TW-1:0] SET_LD  = TW'(nfh_pkg::T_SETUP_CYC - 1);
	localparam logic [TW-1:0] LOW_LD  = TW'(nfh_pkg::T_LOW_CYC - 1);
	localparam logic [TW-1:0] HOLD_LD = TW'(nfh_pkg::T_HOLD_CYC - 1);
	localparam logic [TW-1:0] BUSY_LD = TW'(nfh_pkg::T_BUSY_CYC - 1);

	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_CMD1   = 3'h1,
		S_ADDR   = 3'h2,
		S_DIN    = 3'h3,
		S_CMD2   = 3'h4,
		S_WBUSY  = 3'h5,
		S_DOUT   = 3'h6,
		S_FINISH = 3'h7
	} nfh_st_t;

	typedef enum logic [1:0] {
		PH_SET  = 2'h0,
		PH_LOW  = 2'h1,
		PH_HOLD = 2'h2
	} nfh_ph_t;

	// ------------------------------------------------------------
	// Operation decoding
	// ------------------------------------------------------------
	function automatic nfh_pkg::nfh_desc_t nfh_decode(
		input nfh_pkg::nfh_op_t op, input logic [1:0] ext);
		nfh_pkg::nfh_desc_t d;
		d = '0;
		d.addrFirst = '0;
		d.addrCnt   = nfh_pkg::ADDR_FULL_CNT;
		case (op)
			nfh_pkg::OP_READ: begin
				d.cmd1 = nfh_pkg::CMD_READ;
				d.cmd2 = nfh_pkg::CMD_READ_GO;
				d.hasCmd2 = 1'b1; d.waitBusy = 1'b1; d.dataOut = 1'b1;
			end
			nfh_pkg::OP_READ_CB: begin
				d.cmd1 = nfh_pkg::CMD_READ;
				d.cmd2 = nfh_pkg::CMD_READ_CB;
				d.hasCmd2 = 1'b1; d.waitBusy = 1'b1;
			end
			nfh_pkg::OP_CACHE_RD: begin
				d.cmd1 = nfh_pkg::CMD_READ;
				d.cmd2 = nfh_pkg::CMD_CACHE_RD;
				d.hasCmd2 = 1'b1; d.waitBusy = 1'b1; d.dataOut = 1'b1;
			end
			nfh_pkg::OP_CACHE_END: begin
				d.cmd1 = nfh_pkg::CMD_CACHE_END;
				d.addrCnt = '0; d.waitBusy = 1'b1;
			end
			nfh_pkg::OP_PROG, nfh_pkg::OP_CACHE_PROG: begin
				d.cmd1 = nfh_pkg::CMD_PROG;
				d.cmd2 = (op == nfh_pkg::OP_PROG) ? nfh_pkg::CMD_PROG_GO
					: nfh_pkg::CMD_CACHE_PG;
				d.hasCmd2 = 1'b1; d.dataIn = 1'b1;
				d.waitBusy = 1'b1; d.modify = 1'b1;
			end
			nfh_pkg::OP_CB_PROG: begin
				d.cmd1 = nfh_pkg::CMD_CB_PROG;
				d.cmd2 = nfh_pkg::CMD_PROG_GO;
				d.hasCmd2 = 1'b1; d.dataIn = 1'b1;
				d.waitBusy = 1'b1; d.modify = 1'b1;
			end
			nfh_pkg::OP_ERASE: begin
				d.cmd1 = nfh_pkg::CMD_ERASE;
				d.cmd2 = nfh_pkg::CMD_ERASE_GO;
				d.addrFirst = nfh_pkg::ADDR_ROW_IDX;
				d.addrCnt = nfh_pkg::ADDR_ROW_CNT;
				d.hasCmd2 = 1'b1; d.waitBusy = 1'b1; d.modify = 1'b1;
			end
			nfh_pkg::OP_READ_ID: begin
				d.cmd1 = nfh_pkg::CMD_READ_ID;
				d.addrFirst = nfh_pkg::ADDR_ZERO_IDX;
				d.addrCnt = 3'h1; d.dataOut = 1'b1;
			end
			nfh_pkg::OP_RESET: begin
				d.cmd1 = nfh_pkg::CMD_RESET;
				d.addrCnt = '0; d.waitBusy = 1'b1;
			end
			nfh_pkg::OP_STATUS, nfh_pkg::OP_EXT_STAT: begin
				d.cmd1 = (op == nfh_pkg::OP_STATUS) ? nfh_pkg::CMD_STATUS
					: nfh_pkg::CMD_EXT_STAT + {6'h00, ext};
				d.addrCnt = '0; d.dataOut = 1'b1;
			end
			nfh_pkg::OP_RAND_OUT: begin
				d.cmd1 = nfh_pkg::CMD_RAND_OUT;
				d.cmd2 = nfh_pkg::CMD_RAND_GO;
				d.addrCnt = nfh_pkg::ADDR_COL_CNT;
				d.hasCmd2 = 1'b1; d.dataOut = 1'b1;
			end
			nfh_pkg::OP_RAND_IN: begin
				d.cmd1 = nfh_pkg::CMD_CB_PROG;
				d.addrCnt = nfh_pkg::ADDR_COL_CNT;
				d.dataIn = 1'b1; d.modify = 1'b1;
			end
			default: d.addrCnt = '0;
		endcase
		return d;
	endfunction

	// Stages always run in this order; skip those the operation lacks
	function automatic nfh_st_t nfh_next(input nfh_st_t s,
		input nfh_pkg::nfh_desc_t d, input logic haveLen);
		if (s == S_CMD1 && d.addrCnt != '0)
			return S_ADDR;
		if (s <= S_ADDR && d.dataIn && haveLen)
			return S_DIN;
		if (s <= S_DIN && d.hasCmd2)
			return S_CMD2;
		if (s <= S_CMD2 && d.waitBusy)
			return S_WBUSY;
		if (s <= S_WBUSY && d.dataOut && haveLen)
			return S_DOUT;
		return S_FINISH;
	endfunction

	// ------------------------------------------------------------
	// Write data buffer and address bytes
	// ------------------------------------------------------------
	nfh_stream_if #(.WIDTH(16)) wrIn ();
	nfh_stream_if #(.WIDTH(16)) wrOut ();

	assign wrIn.valid = wrValid;
	assign wrIn.data  = wrData;
	assign wrReady    = wrIn.ready;

	nfh_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.inPort  (wrIn.snk),
		.outPort (wrOut.src)
	);

	logic [29:0] addr_r, addr_nxt;
	logic [7:0]  cycleByte [6];

	nfh_addr_map #(.BUS16(BUS16)) u_map (
		.addr      (addr_r),
		.cycleByte (cycleByte)
	);

	// ------------------------------------------------------------
	// Sequencer and pin state
	// ------------------------------------------------------------
	nfh_st_t            st_r, st_nxt, goSt;
	nfh_ph_t            ph_r, ph_nxt;
	nfh_pkg::nfh_desc_t desc_r, desc_nxt;
	logic [TW-1:0]      tmr_r, tmr_nxt;
	logic [2:0]         aIdx_r, aIdx_nxt, aLeft_r, aLeft_nxt;
	logic [LEN_W-1:0]   cnt_r, cnt_nxt;
	logic               haveLen_r, haveLen_nxt;
	logic               enter;
	logic               ceN_r, ceN_nxt, cle_r, cle_nxt, ale_r, ale_nxt;
	logic               weN_r, weN_nxt, reN_r, reN_nxt, wpN_r, wpN_nxt;
	logic [15:0]        io_r, io_nxt, rdData_r, rdData_nxt;
	logic               oeN_r, oeN_nxt, rdValid_r, rdValid_nxt;
	logic               done_r, done_nxt, reqReady_r, reqReady_nxt;

	always_comb begin
		st_nxt = st_r; ph_nxt = ph_r; desc_nxt = desc_r; tmr_nxt = tmr_r;
		aIdx_nxt = aIdx_r; aLeft_nxt = aLeft_r; cnt_nxt = cnt_r;
		haveLen_nxt = haveLen_r; addr_nxt = addr_r;
		ceN_nxt = ceN_r; cle_nxt = cle_r; ale_nxt = ale_r;
		weN_nxt = weN_r; reN_nxt = reN_r; wpN_nxt = wpN_r;
		io_nxt = io_r; oeN_nxt = oeN_r; rdData_nxt = rdData_r;
		rdValid_nxt = 1'b0; done_nxt = 1'b0; reqReady_nxt = reqReady_r;
		wrOut.ready = 1'b0;
		enter = 1'b0;
		goSt = S_FINISH;
		case (st_r)
			S_IDLE: begin
				// Ready again once idle, after reset or a finish
				reqReady_nxt = 1'b1;
				// New work only when nothing is in flight
				if (reqValid && reqReady_r) begin
					desc_nxt    = nfh_decode(reqOp, reqAddr[1:0]);
					addr_nxt    = reqAddr;
					cnt_nxt     = reqLen;
					haveLen_nxt = (reqLen != '0);
					aIdx_nxt    = desc_nxt.addrFirst;
					aLeft_nxt   = desc_nxt.addrCnt;
					reqReady_nxt = 1'b0;
					ceN_nxt     = 1'b0;
					// Unprotect only for program or erase
					wpN_nxt     = desc_nxt.modify;
					cle_nxt     = 1'b1;
					io_nxt      = {8'h00, desc_nxt.cmd1};
					oeN_nxt     = 1'b0;
					ph_nxt      = PH_SET;
					tmr_nxt     = SET_LD;
					st_nxt      = S_CMD1;
				end
			end
			S_CMD1, S_ADDR, S_CMD2, S_DIN, S_DOUT: begin
				if (tmr_r != '0) begin
					tmr_nxt = tmr_r - 1'b1;
				end else begin
					case (ph_r)
						PH_SET: begin
							if (st_r == S_DOUT) begin
								reN_nxt = 1'b0;
								ph_nxt = PH_LOW;
								tmr_nxt = LOW_LD;
							end else if (st_r != S_DIN || wrOut.valid) begin
								// Stall here while the buffer is empty
								if (st_r == S_DIN) begin
									wrOut.ready = 1'b1;
									io_nxt = BUS16 ? wrOut.data
										: {8'h00, wrOut.data[7:0]};
								end
								weN_nxt = 1'b0;
								ph_nxt = PH_LOW;
								tmr_nxt = LOW_LD;
							end
						end
						PH_LOW: begin
							// Capture on the last low cycle
							if (st_r == S_DOUT) begin
								rdData_nxt = BUS16 ? ioIn : {8'h00, ioIn[7:0]};
								rdValid_nxt = 1'b1;
								reN_nxt = 1'b1;
							end else begin
								weN_nxt = 1'b1;      // Rising edge latches
							end
							ph_nxt = PH_HOLD;
							tmr_nxt = HOLD_LD;
						end
						PH_HOLD: begin
							enter = 1'b1;
							if (st_r == S_ADDR && aLeft_r > 3'h1) begin
								goSt = S_ADDR;
								aIdx_nxt = aIdx_r + 1'b1;
								aLeft_nxt = aLeft_r - 1'b1;
							end else if ((st_r == S_DIN || st_r == S_DOUT)
								&& cnt_r > LEN_W'(1)) begin
								goSt = st_r;
								cnt_nxt = cnt_r - 1'b1;
							end else begin
								goSt = nfh_next(st_r, desc_r, haveLen_r);
							end
						end
						default: ph_nxt = PH_SET;
					endcase
				end
			end
			S_WBUSY: begin
				// Give the device time to pull ready/busy low
				if (tmr_r != '0) begin
					tmr_nxt = tmr_r - 1'b1;
				end else if (readyBusyN) begin
					enter = 1'b1;
					goSt = nfh_next(S_WBUSY, desc_r, haveLen_r);
				end
			end
			S_FINISH: begin
				// Deselect, protect and release the bus
				ceN_nxt = 1'b1;
				wpN_nxt = 1'b0;
				cle_nxt = 1'b0;
				ale_nxt = 1'b0;
				oeN_nxt = 1'b1;
				done_nxt = 1'b1;
				reqReady_nxt = 1'b1;
				st_nxt = S_IDLE;
			end
			default: st_nxt = S_FINISH;
		endcase

		// Set up latch strobes and bus for the next stage
		if (enter) begin
			st_nxt  = goSt;
			ph_nxt  = PH_SET;
			tmr_nxt = (goSt == S_WBUSY) ? BUSY_LD : SET_LD;
			cle_nxt = (goSt == S_CMD2);
			ale_nxt = (goSt == S_ADDR);
			oeN_nxt = !(goSt == S_ADDR || goSt == S_CMD2 || goSt == S_DIN);
			if (goSt == S_CMD2)
				io_nxt = {8'h00, desc_r.cmd2};
			else if (goSt == S_ADDR)
				io_nxt = {8'h00, cycleByte[aIdx_nxt]};
			else if (goSt != S_DIN)
				io_nxt = 16'h0000;
		end
	end

	// Registers only; reset leaves the device deselected and protected
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_r <= S_IDLE; ph_r <= PH_SET; desc_r <= '0; tmr_r <= '0;
			aIdx_r <= '0; aLeft_r <= '0; cnt_r <= '0; haveLen_r <= 1'b0;
			addr_r <= '0;
			ceN_r <= 1'b1; cle_r <= 1'b0; ale_r <= 1'b0;
			weN_r <= 1'b1; reN_r <= 1'b1;
			wpN_r <= 1'b0;
			io_r <= 16'h0000; oeN_r <= 1'b1; rdData_r <= 16'h0000;
			rdValid_r <= 1'b0; done_r <= 1'b0; reqReady_r <= 1'b0;
		end else begin
			st_r <= st_nxt; ph_r <= ph_nxt; desc_r <= desc_nxt;
			tmr_r <= tmr_nxt; aIdx_r <= aIdx_nxt; aLeft_r <= aLeft_nxt;
			cnt_r <= cnt_nxt; haveLen_r <= haveLen_nxt; addr_r <= addr_nxt;
			ceN_r <= ceN_nxt; cle_r <= cle_nxt; ale_r <= ale_nxt;
			weN_r <= weN_nxt; reN_r <= reN_nxt; wpN_r <= wpN_nxt;
			io_r <= io_nxt; oeN_r <= oeN_nxt; rdData_r <= rdData_nxt;
			rdValid_r <= rdValid_nxt; done_r <= done_nxt;
			reqReady_r <= reqReady_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from flops
	// ------------------------------------------------------------
	// Strobe widths are whole multi-cycle phases, never 5 ns slivers
	assign ceN         = ceN_r;
	assign cmdLatch    = cle_r;
	assign addrLatch   = ale_r;
	assign weN         = weN_r;
	assign readStrobeN = reN_r;
	assign wpN         = wpN_r;
	assign ioOut       = io_r;
	assign ioOeN       = oeN_r;
	assign rdData      = rdData_r;
	assign rdValid     = rdValid_r;
	assign done        = done_r;
	assign reqReady    = reqReady_r;
endmodule // nfh_host

// ### test/nfh_host_checker.sv
// Pin-protocol assertions for the flash host controller.
// Assumes it is bound onto nfh_host and sees only its ports.
`timescale 1ns/1ps
module nfh_host_checker (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        reqReady,
	input  wire logic        rdValid,
	input  wire logic        ceN,
	input  wire logic        cmdLatch,
	input  wire logic        addrLatch,
	input  wire logic        weN,
	input  wire logic        readStrobeN,
	input  wire logic        wpN,
	input  wire logic [15:0] ioOut,
	input  wire logic        ioOeN
);
	// ------------------------------------------------------------
	// Strobe and latch relations
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Whole write pulse; far wider than any glitch the part ignores
	sequence s_weHigh;
		weN [*4];
	endsequence
	sequence s_wePulse;
		(!weN) [*5] ##1 s_weHigh;
	endsequence
	a_cmd_pins: assert property (
		$rose(weN) && cmdLatch |-> !ceN && !addrLatch && readStrobeN
		&& ioOut[15:8] == 8'h00) else $error("command cycle pins wrong");
	a_addr_pins: assert property (
		$rose(weN) && addrLatch |-> !ceN && !cmdLatch && readStrobeN
		&& ioOut[15:8] == 8'h00) else $error("address cycle pins wrong");
	a_data_pins: assert property (
		$rose(weN) && !cmdLatch && !addrLatch |-> !ceN && wpN
		&& readStrobeN) else $error("data cycle pins wrong");
	a_read_pins: assert property (
		$fell(readStrobeN) |-> !ceN && weN && !cmdLatch && !addrLatch
		&& ioOeN) else $error("read cycle pins wrong");
	a_read_word: assert property (
		$rose(readStrobeN) |-> rdValid) else $error("read word lost");
	a_we_width: assert property (
		$fell(weN) |-> s_wePulse) else $error("write strobe width wrong");
	a_idle_safe: assert property (
		reqReady |-> ceN && !wpN && ioOeN) else $error("idle pins wrong");
	a_wp_modify: assert property (
		$rose(weN) && cmdLatch && ioOut[7:0] inside {8'h80, 8'h60, 8'h85}
		|-> wpN) else $error("modify command while protected");
endmodule // nfh_host_checker

bind nfh_host nfh_host_checker nfh_host_checker_inst (.mclk(mclk),
	.rst_n(rst_n), .reqReady(reqReady), .rdValid(rdValid), .ceN(ceN),
	.cmdLatch(cmdLatch), .addrLatch(addrLatch), .weN(weN),
	.readStrobeN(readStrobeN), .wpN(wpN), .ioOut(ioOut), .ioOeN(ioOeN));

// ### test/nfh_flash_model.sv
// Behavioural flash device seen only through its pins.
// Assumes an outside pull-up turns rbLow into the ready/busy line.
`timescale 1ns/1ps
module nfh_flash_model (
	input  wire logic        ceN,
	input  wire logic        cmdLatch,
	input  wire logic        addrLatch,
	input  wire logic        weN,
	input  wire logic        readStrobeN,
	input  wire logic        wpN,
	input  wire logic [15:0] ioOut,
	output logic      [15:0] ioIn,
	output logic             rbLow
);
	// ------------------------------------------------------------
	// Latched traffic, kept for the bench to inspect
	// ------------------------------------------------------------
	logic [7:0] cmdQ[$];
	logic [7:0] addrQ[$];
	logic [7:0] dataQ[$];
	logic [7:0] colCnt = 8'h00;
	int         badCmd = 0;
	int         modStarts = 0;
	initial rbLow = 1'b0;
	initial ioIn = 16'h5a5a;
	// Cycle kind decoded at write strobe rise; other mixes ignored
	always @(posedge weN) begin
		if (!ceN && readStrobeN && cmdLatch && !addrLatch) begin
			if (rbLow && !(ioOut[7:0] inside {8'hff, 8'h70, [8'h72:8'h75]}))
				badCmd++;
			cmdQ.push_back(ioOut[7:0]);
			if (wpN && ioOut[7:0] inside {8'h10, 8'h15, 8'hd0})
				modStarts++;
			if (ioOut[7:0] inside {8'h10, 8'h15, 8'hd0, 8'h30, 8'h31, 8'h34,
				8'h35, 8'hff}) begin
				rbLow = 1'b1;
				rbLow <= #300 1'b0;
			end
		end else if (!ceN && readStrobeN && addrLatch && !cmdLatch) begin
			if (addrQ.size() == 0)
				colCnt = ioOut[7:0];
			addrQ.push_back(ioOut[7:0]);
		end else if (!ceN && readStrobeN && !addrLatch && !cmdLatch && wpN)
			dataQ.push_back(ioOut[7:0]);
	end
	// Word out on strobe fall; column moves on each fall
	always @(negedge readStrobeN) begin
		if (!ceN && weN && !cmdLatch && !addrLatch) begin
			ioIn = {~colCnt, colCnt};
			colCnt++;
		end
	end
	// Released bus must not keep its last word
	always @(posedge readStrobeN or posedge ceN) ioIn = ~ioIn;
endmodule // nfh_flash_model

// ### test/nfh_host_test.sv
// Self-checking bench for the NAND flash host controller.
// Assumes the flash model on the pins and a pull-up on ready/busy.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	num_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module nfh_host_test;
	// ------------------------------------------------------------
	// Stimulus, wiring and instances
	// ------------------------------------------------------------
	logic             mclk = 1'b0;
	logic             rst_n = 1'b0;
	logic             reqValid = 1'b0;
	nfh_pkg::nfh_op_t reqOp = nfh_pkg::OP_STATUS;
	logic [29:0]      reqAddr = 30'h0;
	logic [11:0]      reqLen = 12'h000;
	logic             wrValid = 1'b0;
	logic [15:0]      wrData = 16'h0000;
	logic             reqReady, done, wrReady, rdValid, ceN, cmdLatch;
	logic             addrLatch, weN, readStrobeN, wpN, ioOeN, rbLow;
	logic [15:0]      rdData, ioOut, ioIn;
	wire              readyBusyN = rbLow ? 1'b0 : 1'b1;
	int               num_errors = 0;
	int               comparisons = 0;
	int               cycles = 0;
	logic [15:0]      rdQ[$];
	// Per op: first code, last code, address byte count
	logic [19:0] opTbl [14] = '{20'h00305, 20'h00355, 20'h00315, 20'h34340,
		20'h80105, 20'h80155, 20'h85105, 20'h60d03, 20'h90901, 20'hffff0,
		20'h70700, 20'h74740, 20'h05e02, 20'h85852};
	always #2.5 mclk = ~mclk;
	nfh_host #(.BUS16(1'b0), .LEN_W(12), .FIFO_DEPTH(8)) nfh_host_inst (
		.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp),
		.reqAddr(reqAddr), .reqLen(reqLen), .reqReady(reqReady),
		.done(done), .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
		.rdValid(rdValid), .rdData(rdData), .ceN(ceN), .cmdLatch(cmdLatch),
		.addrLatch(addrLatch), .weN(weN), .readStrobeN(readStrobeN),
		.wpN(wpN), .ioOut(ioOut), .ioOeN(ioOeN), .ioIn(ioIn),
		.readyBusyN(readyBusyN));
	nfh_flash_model nfh_flash_model_inst (.ceN(ceN), .cmdLatch(cmdLatch),
		.addrLatch(addrLatch), .weN(weN), .readStrobeN(readStrobeN),
		.wpN(wpN), .ioOut(ioOut), .ioIn(ioIn), .rbLow(rbLow));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Generous ceiling; whole run needs under two thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	function automatic logic [7:0] abyte(input logic [29:0] a, input int i);
		case (i)
			0: return a[7:0];
			1: return {4'h0, a[11:8]};
			2: return a[19:12];
			3: return a[27:20];
			default: return {6'h00, a[29:28]};
		endcase
	endfunction
	// One request, held until taken, then read words gathered until done
	task automatic do_op(input nfh_pkg::nfh_op_t op, input logic [29:0] a,
		input logic [11:0] n);
		int k;
		nfh_flash_model_inst.cmdQ.delete();
		nfh_flash_model_inst.addrQ.delete();
		nfh_flash_model_inst.dataQ.delete();
		rdQ.delete();
		@(negedge mclk);
		reqValid = 1'b1;
		reqOp = op;
		reqAddr = a;
		reqLen = n;
		for (k = 0; k < 1000 && reqReady !== 1'b1; k++) @(negedge mclk);
		@(negedge mclk);
		reqValid = 1'b0;
		for (k = 0; k < 5000 && done !== 1'b1; k++) begin
			if (rdValid === 1'b1)
				rdQ.push_back(rdData);
			@(negedge mclk);
		end
		`CHK("done", 1'b1, done)
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		`CHK("ceN", 1'b1, ceN)
		`CHK("wpN", 1'b0, wpN)
		`CHK("ioOeN", 1'b1, ioOeN)
	endtask
	// Fill the FIFO until it refuses, then program and drain it
	task automatic t_program();
		int i;
		int n;
		n = 0;
		for (i = 0; i < 12; i++) begin
			@(negedge mclk);
			wrValid = (wrReady === 1'b1);
			wrData = 16'h00a0 + n[15:0];
			if (wrReady === 1'b1)
				n++;
		end
		`CHK("fifo words", 8, n)
		do_op(nfh_pkg::OP_PROG, 30'h3abcdef1, 12'h008);
		`CHK("codes", 16'h8010, {nfh_flash_model_inst.cmdQ[0],
			nfh_flash_model_inst.cmdQ[1]})
		for (i = 0; i < 5; i++)
			`CHK("addr", abyte(30'h3abcdef1, i),
				nfh_flash_model_inst.addrQ[i])
		`CHK("dcount", 8, nfh_flash_model_inst.dataQ.size())
		for (i = 0; i < 8; i++)
			`CHK("data", 8'ha0 + i[7:0],
				nfh_flash_model_inst.dataQ[i])
		`CHK("drained", 1'b1, wrReady)
		`CHK("started", 1, nfh_flash_model_inst.modStarts)
	endtask
	task automatic t_read();
		int i;
		do_op(nfh_pkg::OP_READ, 30'h0000003c, 12'h003);
		`CHK("words", 3, rdQ.size())
		for (i = 0; i < 3; i++)
			`CHK("rdData", {8'h00, 8'h3c + i[7:0]}, rdQ[i])
	endtask
	// Every op: codes, address bytes and their order
	task automatic t_cmd_set();
		int i;
		int j;
		int c;
		logic [29:0] a;
		a = 30'h02468ace;
		for (i = 0; i < 14; i++) begin
			do_op(nfh_pkg::nfh_op_t'(i), a, 12'h000);
			c = int'(opTbl[i][3:0]);
			`CHK("first", opTbl[i][19:12], nfh_flash_model_inst.cmdQ[0])
			`CHK("last", opTbl[i][11:4], nfh_flash_model_inst.cmdQ[$])
			`CHK("acount", c, nfh_flash_model_inst.addrQ.size())
			for (j = 0; j < c; j++)
				`CHK("abyte", c == 1 ? 8'h00 : abyte(a, j + (c == 3 ? 2 : 0)),
					nfh_flash_model_inst.addrQ[j])
		end
		`CHK("busy cmds", 0, nfh_flash_model_inst.badCmd)
	endtask
	initial begin
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		t_reset();
		t_program();
		t_read();
		t_cmd_set();
		finish_test();
	end
endmodule // nfh_host_test
